// ---- hdl/sse_exec.sv ----
// execution unit for increment-skip, bit/byte skip and subtract instructions
`timescale 1ns/100ps
`default_nettype none
module sse_exec (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_valid,
   input  wire logic [1:0]            i_op,
   input  wire logic [7:0]            i_addr,
   input  wire logic [2:0]            i_bit_sel,
   input  wire logic [7:0]            i_mem_rdata,
   output logic                       o_ready,
   output logic [7:0]                 o_mem_addr,
   output logic                       o_mem_we,
   output logic [7:0]                 o_mem_wdata,
   output logic                       o_skip,
   output logic                       o_done,
   output logic [7:0]                 o_acc,
   output logic                       o_carry_flag,
   output logic                       o_aux_carry_flag,
   output logic                       o_zero_flag,
   output logic                       o_overflow_flag,
   output logic                       o_signed_compare_flag,
   output logic                       o_compare_zero_flag
);
   typedef enum logic [1:0] {
      SSE_IDLE,
      SSE_READ,
      SSE_EXEC,
      SSE_DUMMY
   } sse_state_t;

   sse_state_t       state_reg;
   sse_state_t       state_next;
   sse_pkg::sse_op_t op_reg;
   logic [7:0]       addr_reg;
   logic [2:0]       bit_reg;
   logic [7:0]       accumulator_reg;
   logic [7:0]       accumulator_next;
   logic             carry_flag_reg;
   logic             aux_carry_flag_reg;
   logic             zero_flag_reg;
   logic             overflow_flag_reg;
   logic             signed_compare_flag_reg;
   logic             compare_zero_flag_reg;
   logic [7:0]       inc_sum;
   logic [7:0]       sub_diff;
   logic [5:0]       sub_flags;
   logic             skip_next;
   logic             in_idle;
   logic             in_exec;
   logic             in_dummy;
   logic             take;
   logic             op_is_inc;
   logic             op_is_nz;
   logic             op_is_sub;
   logic             flag_load;
   logic             finish_now;
   logic             ready_reg;
   logic             we_reg;
   logic [7:0]       wdata_reg;
   logic             skip_reg;
   logic             done_reg;

   sse_sub_flags u_sub (
      .i_a     (accumulator_reg),
      .i_b     (i_mem_rdata),
      .o_diff  (sub_diff),
      .o_flags (sub_flags)
   );

   // state and opcode decode shared by the processes below
   assign in_idle = (state_reg == SSE_IDLE);
   assign in_exec = (state_reg == SSE_EXEC);
   assign in_dummy = (state_reg == SSE_DUMMY);
   // requests are looked at in idle only; a busy block ignores i_valid
   assign take = in_idle && i_valid;
   assign op_is_inc = (op_reg == sse_pkg::SSE_OP_INC_SKIP_ZERO_TO_ACC);
   assign op_is_nz = (op_reg == sse_pkg::SSE_OP_SKIP_IF_NONZERO);
   assign op_is_sub = (op_reg == sse_pkg::SSE_OP_SUB_ACC_MEM);
   // only subtract loads flags; the three skips leave them alone
   assign flag_load = in_exec && op_is_sub;
   // last cycle of a plain instruction, or the dummy cycle after a skip
   assign finish_now = (in_exec && !skip_next) || in_dummy;

   // increment kept to eight bits so an all-ones byte wraps to zero
   always_comb begin
      inc_sum = 8'(i_mem_rdata + sse_pkg::BYTE_ONE);
   end

   // skip decision per opcode, evaluated with read data in the exec state
   always_comb begin
      skip_next = 1'b0;
      unique case (op_reg)
         sse_pkg::SSE_OP_INC_SKIP_ZERO_TO_ACC: begin
            skip_next = (inc_sum == sse_pkg::BYTE_ZERO);
         end
         sse_pkg::SSE_OP_SKIP_IF_BIT_SET: begin
            skip_next = i_mem_rdata[bit_reg];
         end
         sse_pkg::SSE_OP_SKIP_IF_NONZERO: begin
            skip_next = (i_mem_rdata != sse_pkg::BYTE_ZERO);
         end
         // subtraction never skips
         sse_pkg::SSE_OP_SUB_ACC_MEM: begin
            skip_next = 1'b0;
         end
      endcase
   end

   // next state: idle, memory read, execute, optional dummy cycle
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SSE_IDLE: begin
            if (i_valid) begin
               state_next = SSE_READ;
            end
         end
         SSE_READ: state_next = SSE_EXEC;
         SSE_EXEC: state_next = skip_next ? SSE_DUMMY : SSE_IDLE;
         SSE_DUMMY: state_next = SSE_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= SSE_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // opcode capture on acceptance
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         op_reg <= sse_pkg::SSE_OP_INC_SKIP_ZERO_TO_ACC;
      end else if (take) begin
         op_reg <= sse_pkg::sse_op_t'(i_op);
      end
   end

   // operand address capture; it also drives the memory address port
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         addr_reg <= sse_pkg::BYTE_ZERO;
      end else if (take) begin
         addr_reg <= i_addr;
      end
   end

   // bit index capture, only meaningful for the bit-test skip
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bit_reg <= '0;
      end else if (take) begin
         bit_reg <= i_bit_sel;
      end
   end

   // accumulator next value: increment-skip and subtract write it, the rest keep it
   always_comb begin
      accumulator_next = accumulator_reg;
      if (in_exec && op_is_inc) begin
         accumulator_next = inc_sum;
      end else if (in_exec && op_is_sub) begin
         accumulator_next = sub_diff;
      end
   end

   // accumulator register; memory is never written by increment-skip
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         accumulator_reg <= sse_pkg::ACC_RESET;
      end else begin
         accumulator_reg <= accumulator_next;
      end
   end

   // carry: one when nothing is borrowed out of bit 7
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         carry_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_C];
      end else if (flag_load) begin
         carry_flag_reg <= sub_flags[sse_pkg::FLAG_C];
      end
   end

   // aux carry: one when the low nibble needs no borrow
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aux_carry_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_AC];
      end else if (flag_load) begin
         aux_carry_flag_reg <= sub_flags[sse_pkg::FLAG_AC];
      end
   end

   // zero flag of the difference
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         zero_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_Z];
      end else if (flag_load) begin
         zero_flag_reg <= sub_flags[sse_pkg::FLAG_Z];
      end
   end

   // signed overflow of the difference
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         overflow_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_OV];
      end else if (flag_load) begin
         overflow_flag_reg <= sub_flags[sse_pkg::FLAG_OV];
      end
   end

   // signed compare keeps the true sign even when the difference overflows
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         signed_compare_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_SC];
      end else if (flag_load) begin
         signed_compare_flag_reg <= sub_flags[sse_pkg::FLAG_SC];
      end
   end

   // compare zero follows the zero flag for this byte-wide subtract
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         compare_zero_flag_reg <= sse_pkg::FLAGS_RESET[sse_pkg::FLAG_CZ];
      end else if (flag_load) begin
         compare_zero_flag_reg <= sub_flags[sse_pkg::FLAG_CZ];
      end
   end

   // write-back strobe for byte-nonzero skip, whether or not it skips
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         we_reg <= 1'b0;
      end else begin
         we_reg <= in_exec && op_is_nz;
      end
   end

   // write data is the byte just read, so the location keeps its value
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wdata_reg <= sse_pkg::BYTE_ZERO;
      end else if (in_exec) begin
         wdata_reg <= i_mem_rdata;
      end
   end

   // skip pulse in the result cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         skip_reg <= 1'b0;
      end else begin
         skip_reg <= in_exec && skip_next;
      end
   end

   // done pulse; the dummy cycle pushes it back by one, so a skip costs one extra cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= finish_now;
      end
   end

   // ready: idle with nothing offered, or about to return to idle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= (in_idle && !i_valid) || finish_now;
      end
   end

   // memory port and result pulses, each straight from its register
   assign o_ready = ready_reg;
   assign o_mem_addr = addr_reg;
   assign o_mem_we = we_reg;
   assign o_mem_wdata = wdata_reg;
   assign o_skip = skip_reg;
   assign o_done = done_reg;

   // accumulator and flags, each straight from its register
   assign o_acc = accumulator_reg;
   assign o_carry_flag = carry_flag_reg;
   assign o_aux_carry_flag = aux_carry_flag_reg;
   assign o_zero_flag = zero_flag_reg;
   assign o_overflow_flag = overflow_flag_reg;
   assign o_signed_compare_flag = signed_compare_flag_reg;
   assign o_compare_zero_flag = compare_zero_flag_reg;
endmodule
`default_nettype wire

// ---- hdl/sse_pkg.sv ----
// package for the skip-and-subtract execution block
package sse_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int BIT_SEL_W = 3;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   // flag vector positions
   localparam int FLAG_W = 6;
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_SC = 4;
   localparam int FLAG_CZ = 5;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   // opcodes presented by the decoder
   typedef enum logic [1:0] {
      SSE_OP_INC_SKIP_ZERO_TO_ACC = 2'h0,
      SSE_OP_SKIP_IF_BIT_SET = 2'h1,
      SSE_OP_SKIP_IF_NONZERO = 2'h2,
      SSE_OP_SUB_ACC_MEM = 2'h3
   } sse_op_t;
endpackage

// ---- hdl/sse_sub_flags.sv ----
// subtractor with status flag generation
`timescale 1ns/100ps
`default_nettype none
module sse_sub_flags (
   input  wire logic [7:0] i_a,
   input  wire logic [7:0] i_b,
   output logic      [7:0] o_diff,
   output logic      [5:0] o_flags
);
   logic [8:0] wide;
   logic [4:0] low;
   logic       z;
   // borrow shows as a missing carry out
   always_comb begin
      wide = {1'b0, i_a} - {1'b0, i_b};
      low = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]};
      o_diff = wide[7:0];
      z = (wide[7:0] == sse_pkg::BYTE_ZERO);
      o_flags = sse_pkg::FLAGS_RESET;
      o_flags[sse_pkg::FLAG_C] = ~wide[8];
      o_flags[sse_pkg::FLAG_AC] = ~low[4];
      o_flags[sse_pkg::FLAG_Z] = z;
      o_flags[sse_pkg::FLAG_OV] = (i_a[7] ^ i_b[7]) & (i_a[7] ^ wide[7]);
      // signed compare uses true sign despite overflow
      o_flags[sse_pkg::FLAG_SC] = wide[7] ^ ((i_a[7] ^ i_b[7]) & (i_a[7] ^ wide[7]));
      o_flags[sse_pkg::FLAG_CZ] = z;
   end
endmodule
`default_nettype wire

// ---- verif/skip_and_subtract_exec_tb.sv ----
// self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module skip_and_subtract_exec_tb;
   logic       i_clk, i_rst, i_valid, o_ready, o_mem_we, o_skip, o_done;
   logic       o_carry_flag, o_aux_carry_flag, o_zero_flag;
   logic       o_overflow_flag, o_signed_compare_flag, o_compare_zero_flag;
   logic [1:0] i_op;
   logic [2:0] i_bit_sel;
   logic [7:0] i_addr, i_mem_rdata, o_mem_addr, o_mem_wdata, o_acc;
   logic [5:0] fl;
   int         mismatches, tests_run;
   assign fl = {o_carry_flag, o_aux_carry_flag, o_zero_flag, o_overflow_flag,
      o_signed_compare_flag, o_compare_zero_flag};
   sse_exec dut_u (.i_clk, .i_rst, .i_valid, .i_op, .i_addr, .i_bit_sel, .i_mem_rdata, .o_ready,
      .o_mem_addr, .o_mem_we, .o_mem_wdata, .o_skip, .o_done, .o_acc, .o_carry_flag,
      .o_aux_carry_flag, .o_zero_flag, .o_overflow_flag, .o_signed_compare_flag,
      .o_compare_zero_flag);
   sse_mem_model mem_u (.i_clk(i_clk), .i_addr(o_mem_addr), .i_we(o_mem_we),
      .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one instruction held until done; i_valid drops in the done cycle so it is not retaken
   task run(input logic [1:0] op, input logic [7:0] a, input logic [2:0] b, input bit es);
      int n, wr, rd;
      bit sk;
      logic [5:0] f0;
      f0 = fl;
      n = 0;
      wr = 0;
      rd = 0;
      chk(o_ready === 1'b1, "idle ready");
      sk = 0;
      i_op = op;
      i_addr = a;
      i_bit_sel = b;
      i_valid = 1'b1;
      do begin
         @(posedge i_clk);
         #1;
         n++;
         sk |= (o_skip === 1'b1);
         wr += (o_mem_we === 1'b1);
         rd += (o_ready === 1'b1);
      end while (o_done !== 1'b1 && n < 20);
      i_valid = 1'b0;
      if (n >= 20) begin
         chk(1'b0, "timeout");
         test_done;
      end
      chk(sk == es, "skip");
      chk(n == (es ? 4 : 3), "cycles");
      chk(wr == int'(op == 2'h2), "writes");
      chk(rd == 1 && o_mem_addr === a, "ready or address");
      if (op != 2'h3) chk(fl === f0, "flags");
      @(posedge i_clk);
      #1;
   endtask
   task t_sub;
      mem_u.mem[8'h10] = 8'h04;
      mem_u.mem[8'h11] = 8'h07;
      mem_u.mem[8'h12] = 8'h10;
      mem_u.mem[8'h13] = 8'hEE;
      mem_u.mem[8'h14] = 8'h80;
      run(2'h0, 8'h10, 3'h0, 1'b0);
      run(2'h3, 8'h11, 3'h0, 1'b0);
      chk(o_acc === 8'hFE && o_carry_flag === 1'b0, "borrow");
      chk(fl === 6'h02, "borrow flags");
      run(2'h3, 8'h12, 3'h0, 1'b0);
      chk(o_acc === 8'hEE && o_carry_flag === 1'b1, "positive");
      chk(fl === 6'h32, "positive flags");
      run(2'h3, 8'h13, 3'h0, 1'b0);
      chk(o_acc === 8'h00 && fl === 6'h39, "zero");
      run(2'h3, 8'h14, 3'h0, 1'b0);
      chk(o_acc === 8'h80 && fl === 6'h14, "overflow");
      $display("t_sub done");
   endtask
   task t_inc;
      mem_u.mem[8'h20] = 8'hFF;
      mem_u.mem[8'h21] = 8'h41;
      run(2'h0, 8'h20, 3'h0, 1'b1);
      chk(o_acc === 8'h00 && mem_u.mem[8'h20] === 8'hFF, "wrap");
      run(2'h0, 8'h21, 3'h0, 1'b0);
      chk(o_acc === 8'h42, "inc");
      $display("t_inc done");
   endtask
   task t_bit;
      mem_u.mem[8'h30] = 8'h80;
      run(2'h1, 8'h30, 3'h7, 1'b1);
      run(2'h1, 8'h30, 3'h6, 1'b0);
      chk(o_acc === 8'h42, "acc kept");
      $display("t_bit done");
   endtask
   task t_nz;
      mem_u.mem[8'h40] = 8'h00;
      mem_u.mem[8'h41] = 8'hA5;
      run(2'h2, 8'h40, 3'h0, 1'b0);
      chk(mem_u.mem[8'h40] === 8'h00, "zero kept");
      run(2'h2, 8'h41, 3'h0, 1'b1);
      chk(mem_u.mem[8'h41] === 8'hA5, "byte kept");
      $display("t_nz done");
   endtask
   initial begin
      mismatches = 0;
      tests_run = 0;
      i_rst = 1'b1;
      i_valid = 1'b0;
      i_op = 2'h0;
      i_addr = 8'h00;
      i_bit_sel = 3'h0;
      repeat (20) @(posedge i_clk);
      #1;
      chk(o_acc === 8'h00 && fl === 6'h00 && o_ready === 1'b0, "reset");
      i_rst = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      t_sub;
      t_inc;
      t_bit;
      t_nz;
      test_done;
   end
endmodule
`default_nettype wire

// ---- verif/sse_exec_properties.sv ----
// port assertions for the execution block
`timescale 1ns/100ps
`default_nettype none
module sse_exec_properties (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic [1:0] i_op,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_mem_rdata,
   input wire logic       o_mem_we,
   input wire logic [7:0] o_mem_wdata,
   input wire logic       o_skip,
   input wire logic       o_done,
   input wire logic [7:0] o_acc,
   input wire logic       o_carry_flag,
   input wire logic       o_zero_flag
);
   logic skip_q;
   logic fin;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // first result cycle: skip pulse, or done not preceded by skip
   always_ff @(posedge i_clk) skip_q <= o_skip;
   assign fin = o_skip | (o_done & ~skip_q);
   property p_skip; o_skip |-> !o_done ##1 o_done; endproperty
   a_skip: assert property (p_skip) else $error("skip not two cycles");
   property p_wb; o_mem_we |-> i_op == 2'h2 && o_mem_wdata == $past(i_mem_rdata); endproperty
   a_wb: assert property (p_wb) else $error("bad write-back");
   property p_inc; fin && i_op == 2'h0 |-> o_acc == 8'($past(i_mem_rdata) + 8'h01); endproperty
   a_inc: assert property (p_inc) else $error("bad increment");
   property p_incs; fin && i_op == 2'h0 |-> o_skip == (o_acc == 8'h00); endproperty
   a_incs: assert property (p_incs) else $error("bad zero skip");
   property p_bit; fin && i_op == 2'h1 |-> o_skip == i_mem_rdata[i_bit_sel]; endproperty
   a_bit: assert property (p_bit) else $error("bad bit skip");
   property p_nz; fin && i_op == 2'h2 |-> o_skip == (o_mem_wdata != 8'h00); endproperty
   a_nz: assert property (p_nz) else $error("bad nonzero skip");
   property p_sub;
      fin && i_op == 2'h3 |-> !o_skip && o_acc == 8'($past(o_acc) - $past(i_mem_rdata));
   endproperty
   a_sub: assert property (p_sub) else $error("bad difference");
   property p_subf; fin && i_op == 2'h3 |-> o_carry_flag == ($past(o_acc) >= $past(i_mem_rdata))
      && o_zero_flag == (o_acc == 8'h00); endproperty
   a_subf: assert property (p_subf) else $error("bad carry or zero");
   property p_keep; fin && i_op != 2'h3 |-> $stable({o_carry_flag, o_zero_flag}); endproperty
   a_keep: assert property (p_keep) else $error("skip op moved flags");
   c_incs: cover property (fin && i_op == 2'h0 && o_skip);
   c_borrow: cover property (fin && i_op == 2'h3 && !o_carry_flag);
   c_wb: cover property (o_mem_we && o_skip);
endmodule
bind sse_exec sse_exec_properties chk_u (.i_clk, .i_rst, .i_op, .i_bit_sel, .i_mem_rdata,
   .o_mem_we, .o_mem_wdata, .o_skip, .o_done, .o_acc, .o_carry_flag, .o_zero_flag);
`default_nettype wire

// ---- verif/sse_mem_model.sv ----
// data memory model for the execution block
`timescale 1ns/100ps
`default_nettype none
module sse_mem_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_addr,
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [256];
   // read is combinational, the block samples it in its exec cycle
   assign o_rdata = mem[i_addr];
   // plain always so the bench may preload bytes directly
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end
endmodule
`default_nettype wire
